// [vfds_pkg.sv]
package vfds_pkg;

  // Core clock
  localparam longint CLK_HZ = 40_000_000;

  // Times in their own units
  localparam longint T_SHUTDOWN_DELAY_MS = 25;
  localparam longint T_UNPLUG_DELAY_US = 20;
  localparam longint T_DISCHARGE_LIMIT_MS = 650;
  localparam longint T_RETRY_WAIT_MS = 765;
  localparam longint T_PS_TRANSITION_MS = 600;

  function automatic longint us_up(longint us);
    longint c;
    c = (us * CLK_HZ + 64'd999_999) / 64'd1_000_000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic longint us_dn(longint us);
    longint c;
    c = (us * CLK_HZ) / 64'd1_000_000;
    return (c < 1) ? 1 : c;
  endfunction

  // Cycle counts
  localparam int unsigned SHUTDOWN_DELAY_CYC = int'(us_up(T_SHUTDOWN_DELAY_MS * 1000));
  localparam int unsigned UNPLUG_DELAY_CYC = int'(us_dn(T_UNPLUG_DELAY_US));
  localparam int unsigned DISCHARGE_LIMIT_CYC = int'(us_dn(T_DISCHARGE_LIMIT_MS * 1000));
  localparam int unsigned RETRY_WAIT_CYC = int'(us_up(T_RETRY_WAIT_MS * 1000));
  localparam int unsigned PS_TRANSITION_CYC = int'(us_up(T_PS_TRANSITION_MS * 1000));
  localparam int CNT_W = 25;

  // Avalon register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FAULT = 4'h8;
  localparam logic [3:0] REG_CAPS = 4'hc;

  // CTRL fields
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_SRC_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // FAULT fields, write one to clear
  localparam int FLT_W = 4;
  localparam int FLT_SLOW = 0;
  localparam int FLT_FAST = 1;
  localparam int FLT_DTO = 2;
  localparam int FLT_OVP_HOLD = 3;

  // STATUS fields
  localparam int ST_GATE_BIT = 4;
  localparam int ST_FULL_BIT = 5;
  localparam int ST_BLEED_BIT = 6;
  localparam int ST_STRAP_BIT = 7;
  localparam int ST_FROM_FAST_BIT = 8;

  // Supply select code for 5 V
  localparam logic [1:0] SEL_5V = 2'h0;

  typedef enum logic [2:0] {
    VFDS_IDLE,
    VFDS_CHECK,
    VFDS_SOURCE,
    VFDS_SD_DELAY,
    VFDS_DIS_HIGH,
    VFDS_DIS_LOW,
    VFDS_RETRY_WAIT
  } vfds_state_t;

endpackage

// [vfds_sequencer.sv]
// Contract
// [RULE_01] Attached without final contract: bleed pulldown and supply bleed current on.
// [RULE_02] Gate enable only after supply-sense voltage checks good.
// [RULE_03] Thermal shutdown turns the full discharge transistor off.
// [RULE_04] Slow fault keeps gate on until VBUS below 5 V slow overvoltage level.
// [RULE_05] Fast fault drops gate at once, then discharges connector side.
// [RULE_06] Both fault classes apply bleed pulldown and supply bleed current.
// [RULE_07] Hard Reset received: 25-35 ms delay; unplug: under 20 us; no Hard Reset sent.
// [RULE_08] Listed protocol and alarm faults: slow shutdown, Hard Reset sent, 25-35 ms delay.
// [RULE_09] Fast overvoltage, overcurrent after first message, override falling edge: fast shutdown.
// [RULE_10] VBUS below fall threshold counts as fast-shutdown event; the code counts it only after the first message, while sourcing.
// [RULE_11] Hard Reset of a slow fault goes out at start of delay.
// [RULE_12] After delay: selects request 5 V, full discharge until 5 V slow level.
// [RULE_13] Then gate off, full discharge until VBUS below 0.725 V.
// [RULE_14] Discharge not done within 650 ms: send Hard Reset, restart discharge.
// [RULE_15] Supply still above fast overvoltage after discharge plus 0.765 s: overvoltage, repeat.
// [RULE_16] Failed discharge handled as slow fault, repeated until success.
// [RULE_17] After VBUS below 0.725 V wait 0.765 s before sourcing again.
// [RULE_18] Mid-voltage pin change sends nothing; pin sampled before each capabilities message.
// [RULE_19] Power-halving pin change forces capabilities recompute and resend.
// [RULE_20] High-power strap sampled once after reset and latched.
// [RULE_21] First variant: 5/12/20, 5/12, 5/20 or 5 V by pin and strap.
// [RULE_22] Second variant: 5/9/15, 5/9, 5/15 or 5 V by pin and strap.
// [RULE_23] Inputs taken on core clock; each timed step counted from it.
`timescale 1ns/1ps
module vfds_sequencer #(
  parameter int unsigned SHUTDOWN_DELAY_CYC = vfds_pkg::SHUTDOWN_DELAY_CYC,
  parameter int unsigned DISCHARGE_LIMIT_CYC = vfds_pkg::DISCHARGE_LIMIT_CYC,
  parameter int unsigned RETRY_WAIT_CYC = vfds_pkg::RETRY_WAIT_CYC,
  parameter int unsigned PS_TRANSITION_CYC = vfds_pkg::PS_TRANSITION_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [vfds_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Threshold comparators
  input wire logic supply_sense_ok,
  input wire logic supply_above_fovp,
  input wire logic vbus_below_sovp5,
  input wire logic vbus_below_safe,
  input wire logic vbus_below_fall,
  input wire logic fast_ovp,
  input wire logic overcurrent,
  input wire logic low_voltage_alarm,
  input wire logic high_voltage_alarm,
  input wire logic thermal_shutdown,
  input wire logic gate_override_input,
  // Configuration pins
  input wire logic high_power_select,
  input wire logic mid_voltage_enable_first,
  input wire logic mid_voltage_enable_second,
  input wire logic power_halving_control,
  // Protocol events
  input wire logic sink_attached,
  input wire logic contract_final,
  input wire logic first_msg_sent,
  input wire logic transition_active,
  input wire logic [1:0] supply_req,
  input wire logic hard_reset_rx,
  input wire logic unexpected_msg,
  input wire logic soft_reset_nak,
  input wire logic request_timeout,
  input wire logic caps_send_req,
  // Power path and discharge
  output logic power_path_gate_enable,
  output logic bleed_pulldown,
  output logic discharge_full,
  output logic supply_bleed_current,
  output logic supply_select_a,
  output logic supply_select_b,
  // Protocol requests
  output logic hard_reset_tx,
  output logic caps_resend,
  output logic [2:0] adv_voltages
);
  import vfds_pkg::*;

  typedef struct packed {
    // Sequencer state and timers
    vfds_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] dto;
    logic [CNT_W-1:0] tcnt;
    // Power path
    logic from_fast;
    logic gate;
    logic full;
    logic full_out;
    logic bleed;
    logic [1:0] sel;
    logic hr_tx;
    logic caps_tx;
    // Pin history and configuration
    logic strap_done;
    logic strap_direct;
    logic mid_q;
    logic gd_prev;
    logic power_halving_control_prev;
    logic [2:0] adv;
    // Register bus side
    logic [1:0] ctrl;
    logic [FLT_W-1:0] fault;
    logic wreq;
    logic [31:0] rdata;
  } vfds_regs_t;

  localparam vfds_regs_t REGS_RESET = '{
    state: VFDS_IDLE,
    cnt: '0,
    dto: '0,
    tcnt: '0,
    from_fast: 1'b0,
    gate: 1'b0,
    full: 1'b0,
    full_out: 1'b0,
    bleed: 1'b0,
    sel: SEL_5V,
    hr_tx: 1'b0,
    caps_tx: 1'b0,
    strap_done: 1'b0,
    strap_direct: 1'b0,
    mid_q: 1'b0,
    gd_prev: 1'b1,
    power_halving_control_prev: 1'b0,
    adv: 3'h1,
    ctrl: CTRL_RESET,
    fault: '0,
    wreq: 1'b1,
    rdata: '0
  };

  // Bit 0: 5 V, bit 1: mid voltage, bit 2: high voltage
  function automatic logic [2:0] adv_decode(input logic mid_en, input logic direct);
    adv_decode = {direct, mid_en, 1'b1};
  endfunction

  function automatic logic [CNT_W-1:0] cyc(input int unsigned c);
    cyc = c[CNT_W-1:0];
  endfunction

  vfds_regs_t s;
  vfds_regs_t n;

  logic active;
  logic fast_fault;
  logic slow_hr_fault;
  logic unplug;
  logic dis_timeout;
  logic [FLT_W-1:0] flt_set;
  logic [FLT_W-1:0] flt_clr;

  always_comb begin
    n = s;
    n.hr_tx = 1'b0;
    n.caps_tx = 1'b0;
    flt_set = '0;
    flt_clr = '0;

    // Faults only count while the port is being powered
    active = (s.state == VFDS_CHECK) || (s.state == VFDS_SOURCE);
    fast_fault = active && (fast_ovp
      || (overcurrent && first_msg_sent)
      || (vbus_below_fall && first_msg_sent && s.state == VFDS_SOURCE)
      || (s.gd_prev && !gate_override_input)); // RULE_09 RULE_10
    slow_hr_fault = active && (thermal_shutdown
      || (low_voltage_alarm && !transition_active)
      || (high_voltage_alarm && !transition_active)
      || (unexpected_msg && transition_active)
      || (s.tcnt == cyc(PS_TRANSITION_CYC))
      || soft_reset_nak || request_timeout); // RULE_08
    unplug = active && !sink_attached;
    // One limit covers both discharge phases together
    dis_timeout = s.dto == cyc(DISCHARGE_LIMIT_CYC);

    // Edge tracking of pins, counted on the core clock
    n.gd_prev = gate_override_input; // RULE_23
    n.power_halving_control_prev = power_halving_control;

    // Strap caught once on the first clock after release
    if (!s.strap_done) begin
      n.strap_done = 1'b1;
      n.strap_direct = high_power_select; // RULE_20
    end else if (s.power_halving_control_prev != power_halving_control) begin
      n.caps_tx = 1'b1; // RULE_19
    end

    // Mid pin read only just before a capabilities message
    if (caps_send_req) begin
      n.mid_q = s.ctrl[CTRL_VARIANT_BIT] ? mid_voltage_enable_second : mid_voltage_enable_first; // RULE_18
    end

    // Advertised set held in a register so the pins never show decode glitches
    n.adv = adv_decode(n.mid_q, n.strap_direct); // RULE_21 RULE_22

    // Supply transition watchdog
    if (s.state == VFDS_SOURCE && transition_active && s.tcnt != cyc(PS_TRANSITION_CYC)) begin
      n.tcnt = s.tcnt + 1'b1; // RULE_08
    end else if (!(s.state == VFDS_SOURCE && transition_active)) begin
      n.tcnt = '0;
    end

    case (s.state)
      VFDS_IDLE: begin
        n.gate = 1'b0;
        n.full = 1'b0;
        n.sel = SEL_5V;
        if (sink_attached && s.ctrl[CTRL_SRC_EN_BIT]) begin
          n.state = VFDS_CHECK;
        end
      end

      VFDS_CHECK, VFDS_SOURCE: begin
        if (fast_fault) begin
          // Supply asked for 5 V at once so a restart never comes up high
          n.gate = 1'b0; // RULE_05
          n.sel = SEL_5V;
          n.full = 1'b1;
          n.hr_tx = 1'b1; // RULE_09
          n.from_fast = 1'b1;
          n.dto = '0;
          n.state = VFDS_DIS_LOW;
          flt_set[FLT_FAST] = 1'b1;
        end else if (slow_hr_fault) begin
          // Gate stays on so the reset goes out while power holds
          n.hr_tx = 1'b1; // RULE_11
          n.cnt = cyc(SHUTDOWN_DELAY_CYC); // RULE_08
          n.state = VFDS_SD_DELAY;
          flt_set[FLT_SLOW] = 1'b1;
        end else if (hard_reset_rx && s.state == VFDS_SOURCE) begin
          // Partner reset itself already: nothing sent back
          n.cnt = cyc(SHUTDOWN_DELAY_CYC); // RULE_07
          n.state = VFDS_SD_DELAY;
          flt_set[FLT_SLOW] = 1'b1;
        end else if (unplug) begin
          // One cycle short of the limit so input latency keeps it under
          n.cnt = cyc(UNPLUG_DELAY_CYC) - 1'b1; // RULE_07
          n.state = VFDS_SD_DELAY;
          flt_set[FLT_SLOW] = 1'b1;
        end else if (s.state == VFDS_CHECK) begin
          if (supply_sense_ok) begin
            // Never drive the connector from a supply that is not up
            n.gate = 1'b1; // RULE_02
            n.state = VFDS_SOURCE;
          end
        end else begin
          // Supply follows the contract only while sourcing
          n.sel = supply_req;
        end
      end

      VFDS_SD_DELAY: begin
        // Gate stays on through the delay
        if (s.cnt <= cyc(1)) begin
          n.sel = SEL_5V; // RULE_12
          n.full = 1'b1;
          n.dto = '0;
          n.state = VFDS_DIS_HIGH;
        end else begin
          n.cnt = s.cnt - 1'b1; // RULE_23
        end
      end

      VFDS_DIS_HIGH, VFDS_DIS_LOW: begin
        n.sel = SEL_5V;
        n.dto = s.dto + 1'b1;
        if (dis_timeout) begin
          // Restart from the first phase; gate may already be off
          n.hr_tx = 1'b1; // RULE_14
          n.full = 1'b1;
          n.dto = '0;
          n.state = VFDS_DIS_HIGH; // RULE_16
          flt_set[FLT_DTO] = 1'b1;
        end else if (s.state == VFDS_DIS_HIGH) begin
          if (vbus_below_sovp5) begin
            n.gate = 1'b0; // RULE_04 RULE_13
            n.state = VFDS_DIS_LOW;
          end
        end else if (vbus_below_safe) begin
          n.full = 1'b0;
          // Connector safe: hold off before sourcing again
          n.cnt = cyc(RETRY_WAIT_CYC); // RULE_17
          n.state = VFDS_RETRY_WAIT;
        end
      end

      VFDS_RETRY_WAIT: begin
        if (s.cnt > cyc(1)) begin
          n.cnt = s.cnt - 1'b1; // RULE_17
        end else if (s.from_fast && supply_above_fovp) begin
          // Supply never bled below the fast level: treat as new overvoltage
          n.hr_tx = 1'b1; // RULE_15
          n.full = 1'b1;
          n.dto = '0;
          n.state = VFDS_DIS_LOW;
          flt_set[FLT_OVP_HOLD] = 1'b1;
        end else begin
          // Clean finish: a new attach may start
          n.from_fast = 1'b0;
          n.state = VFDS_IDLE;
        end
      end

      default: begin
        n.state = VFDS_IDLE;
      end
    endcase

    // Bleed paths while unattached-to-contract and throughout any shutdown
    n.bleed = (sink_attached && !contract_final
      && (n.state == VFDS_CHECK || n.state == VFDS_SOURCE)) // RULE_01
      || (n.state != VFDS_IDLE && n.state != VFDS_CHECK && n.state != VFDS_SOURCE); // RULE_06

    // Junction overheat must never leave the internal FET conducting
    n.full_out = n.full && !thermal_shutdown; // RULE_03

    // Avalon slave: one wait cycle, write lands on the low-waitrequest edge
    n.wreq = !((avs_read || avs_write) && s.wreq);
    if ((avs_read || avs_write) && s.wreq) begin
      n.rdata = '0;
      case (avs_address)
        REG_CTRL: n.rdata[1:0] = s.ctrl;
        REG_STATUS: begin
          n.rdata[2:0] = s.state;
          n.rdata[ST_GATE_BIT] = s.gate;
          n.rdata[ST_FULL_BIT] = s.full_out;
          n.rdata[ST_BLEED_BIT] = s.bleed;
          n.rdata[ST_STRAP_BIT] = s.strap_direct;
          n.rdata[ST_FROM_FAST_BIT] = s.from_fast;
        end
        REG_FAULT: n.rdata[FLT_W-1:0] = s.fault;
        REG_CAPS: n.rdata[2:0] = adv_decode(s.mid_q, s.strap_direct);
        default: n.rdata = '0;
      endcase
    end

    // Write lands only on the edge the master sees waitrequest low
    if (avs_write && !s.wreq) begin
      case (avs_address)
        REG_CTRL: n.ctrl = avs_writedata[1:0];
        REG_FAULT: flt_clr = avs_writedata[FLT_W-1:0];
        default: n.ctrl = s.ctrl;
      endcase
    end

    // A fault in the clearing cycle survives
    n.fault = (s.fault & ~flt_clr) | flt_set;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= REGS_RESET;
    end else begin
      s <= n;
    end
  end

  // Every output is a register field
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign power_path_gate_enable = s.gate;
  assign bleed_pulldown = s.bleed;
  assign supply_bleed_current = s.bleed; // RULE_06
  assign discharge_full = s.full_out;
  assign supply_select_a = s.sel[0];
  assign supply_select_b = s.sel[1];
  assign hard_reset_tx = s.hr_tx;
  assign caps_resend = s.caps_tx;
  assign adv_voltages = s.adv; // RULE_21 RULE_22

endmodule // vfds_sequencer

// [vfds_sva.sv]
`timescale 1ns/1ps
module vfds_sva #(
  parameter int RW = 30
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Inputs watched
  input wire logic supply_sense_ok,
  input wire logic vbus_below_sovp5,
  input wire logic vbus_below_safe,
  input wire logic fast_ovp,
  input wire logic thermal_shutdown,
  input wire logic sink_attached,
  input wire logic contract_final,
  input wire logic power_halving_control,
  // Outputs watched
  input wire logic power_path_gate_enable,
  input wire logic bleed_pulldown,
  input wire logic discharge_full,
  input wire logic supply_bleed_current,
  input wire logic supply_select_a,
  input wire logic supply_select_b,
  input wire logic hard_reset_tx,
  input wire logic caps_resend
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Sourcing under a final contract
  sequence s_src;
    power_path_gate_enable && !discharge_full && !bleed_pulldown;
  endsequence
  // Discharge finished, not cut by thermal shutdown
  sequence s_done;
    $fell(discharge_full) && $past(vbus_below_safe) && !$past(thermal_shutdown);
  endsequence
  a_gate_check: assert property ($rose(power_path_gate_enable) |-> $past(supply_sense_ok))
    else $error("gate rose without supply check");
  a_therm_off: assert property (thermal_shutdown |=> !discharge_full)
    else $error("full discharge during thermal shutdown");
  a_fast_cut: assert property (s_src ##0 fast_ovp |=> !power_path_gate_enable && discharge_full && hard_reset_tx)
    else $error("fast fault not handled");
  a_fault_bleed: assert property (s_src ##0 fast_ovp |=> bleed_pulldown && supply_bleed_current)
    else $error("no bleed after fault");
  a_slow_hold: assert property (power_path_gate_enable && discharge_full && !vbus_below_sovp5 |=> power_path_gate_enable)
    else $error("gate dropped early");
  a_gate_drop: assert property (power_path_gate_enable && discharge_full && vbus_below_sovp5 |=> !power_path_gate_enable)
    else $error("gate kept after first phase");
  a_sel_5v: assert property (discharge_full |-> !supply_select_a && !supply_select_b)
    else $error("select not 5 V in discharge");
  a_retry_wait: assert property (s_done |-> !power_path_gate_enable throughout (##RW 1'b1))
    else $error("sourced before retry wait");
  a_unplug_delay: assert property (s_src ##0 $fell(sink_attached) |-> ##[1:802] discharge_full)
    else $error("unplug delay too long");
  a_halving_resend: assert property ($changed(power_halving_control) |-> ##[1:2] caps_resend)
    else $error("no resend on halving change");
  a_bleed_attach: assert property (sink_attached && !contract_final && $past(sink_attached)
    && !$past(contract_final) && power_path_gate_enable |-> bleed_pulldown && supply_bleed_current)
    else $error("no bleed before contract");
endmodule // vfds_sva

bind vfds_sequencer vfds_sva #(.RW(RETRY_WAIT_CYC)) u_sva (.mclk, .rstn, .supply_sense_ok, .vbus_below_sovp5,
  .vbus_below_safe, .fast_ovp, .thermal_shutdown, .sink_attached, .contract_final, .power_halving_control,
  .power_path_gate_enable, .bleed_pulldown, .discharge_full, .supply_bleed_current, .supply_select_a,
  .supply_select_b, .hard_reset_tx, .caps_resend);

// [vfds_partner.sv]
`timescale 1ns/1ps
module vfds_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Power path state
  input wire logic gate,
  input wire logic full,
  // Scenario controls
  input wire logic slow,
  input wire logic stuck,
  input wire logic drop,
  input wire logic ovh,
  // Comparator results
  output logic supply_sense_ok,
  output logic supply_above_fovp,
  output logic vbus_below_sovp5,
  output logic vbus_below_safe,
  output logic vbus_below_fall
);
  int v;
  int s;
  // Stuck holds VBUS so the discharge timeout path is reached
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      v <= 0;
      s <= 0;
    end else begin
      s <= gate ? 0 : (s < 63 ? s + 1 : s);
      if (full && !stuck)
        v <= (v > 6) ? v - (slow ? 1 : 6) : 0;
      else if (gate)
        v <= (v < 80) ? v + 20 : 100;
    end
  end
  // Supply needs 40 cycles with the gate off to settle
  assign supply_sense_ok = s >= 40;
  assign supply_above_fovp = ovh;
  assign vbus_below_sovp5 = v < 30;
  assign vbus_below_safe = v < 4;
  assign vbus_below_fall = drop || v < 2;
endmodule // vfds_partner

// [vfds_sequencer_tb_top.sv]
`timescale 1ns/1ps
module vfds_sequencer_tb_top;
  import vfds_pkg::*;
  // Short counts keep the run small
  localparam int SDC = 20, DLC = 200, RWC = 30, PSC = 50;
  logic mclk = 0, rstn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, hp;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic supply_sense_ok, supply_above_fovp, vbus_below_sovp5, vbus_below_safe, vbus_below_fall;
  logic high_power_select = 0, mid_voltage_enable_first = 0, mid_voltage_enable_second = 0;
  logic power_halving_control = 0, caps_send_req = 0, att = 0, contract_final = 0, first_msg_sent = 0;
  logic slow = 0, stuck = 0, ovh = 0;
  logic [1:0] supply_req = 0;
  logic [12:0] cz = 0;
  logic power_path_gate_enable, bleed_pulldown, discharge_full, supply_bleed_current;
  logic supply_select_a, supply_select_b, hard_reset_tx, caps_resend;
  logic [2:0] adv_voltages;
  int err_total = 0, n_tests = 0, nhr = 0, nres = 0;
  initial forever #12.5 mclk = ~mclk;
  vfds_sequencer #(.SHUTDOWN_DELAY_CYC(SDC), .DISCHARGE_LIMIT_CYC(DLC), .RETRY_WAIT_CYC(RWC),
    .PS_TRANSITION_CYC(PSC)) dut (.mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .supply_sense_ok, .supply_above_fovp, .vbus_below_sovp5,
    .vbus_below_safe, .vbus_below_fall, .fast_ovp(cz[8]), .overcurrent(cz[9]), .low_voltage_alarm(cz[3]),
    .high_voltage_alarm(cz[4]), .thermal_shutdown(cz[5]), .gate_override_input(!cz[10]), .high_power_select,
    .mid_voltage_enable_first, .mid_voltage_enable_second, .power_halving_control,
    .sink_attached(att && !cz[12]), .contract_final, .first_msg_sent, .transition_active(cz[0] || cz[7]),
    .supply_req, .hard_reset_rx(cz[6]), .unexpected_msg(cz[0]), .soft_reset_nak(cz[1]),
    .request_timeout(cz[2]), .caps_send_req, .power_path_gate_enable, .bleed_pulldown, .discharge_full,
    .supply_bleed_current, .supply_select_a, .supply_select_b, .hard_reset_tx, .caps_resend, .adv_voltages);
  vfds_partner pm (.mclk, .rstn, .gate(power_path_gate_enable), .full(discharge_full), .slow, .stuck,
    .drop(cz[11]), .ovh, .supply_sense_ok, .supply_above_fovp, .vbus_below_sovp5, .vbus_below_safe,
    .vbus_below_fall);
  // Counted off the sampling edge so tasks see settled totals
  always @(negedge mclk) begin
    nhr += hard_reset_tx;
    nres += caps_resend;
  end
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    if (n >= 50) err_total++;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(0, a, 0, q);
    chk(q, e);
  endtask
  task automatic wfall;
    int k;
    k = 0;
    while (discharge_full !== 1'b0 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 3000) err_total++;
  endtask
  // Attach, source, inject cause i, follow discharge to completion
  task automatic run(input int i, input logic stk, input logic ov);
    int d, h, t, n0;
    logic fast, hr;
    fast = i >= 8 && i <= 11;
    hr = i != 6 && i != 12;
    d = 0;
    h = 0;
    att <= 1;
    slow <= $urandom_range(0, 1);
    while (power_path_gate_enable !== 1'b1 && d < 300) begin
      @(posedge mclk);
      d++;
    end
    chk({bleed_pulldown, supply_bleed_current}, 2'h3);
    supply_req <= $urandom;
    first_msg_sent <= 1;
    contract_final <= 1;
    cyc(3);
    cz[i] <= 1;
    stuck <= stk;
    ovh <= ov;
    for (int k = 1; k <= 900 && discharge_full !== 1'b1; k++) begin
      @(posedge mclk);
      if (k == (i == 7 ? PSC + 10 : 1) && i != 12) cz <= 0;
      if (hard_reset_tx === 1'b1 && h == 0) h = k;
      d = k;
    end
    t = (i == 7) ? h : 2;
    chk(hr ? (i == 7 ? h > PSC : h == 2) : h == 0, 1);
    chk(fast ? d == 2 : i == 12 ? d <= 802 : (d - t >= SDC && d - t <= SDC + 5), 1);
    cyc(1);
    n0 = nhr;
    if (stk) begin
      // Overheat in a stuck discharge must cut the hard pull-down
      cz[5] <= 1;
      cyc(3);
      chk(discharge_full, 0);
      cz[5] <= 0;
      cyc(DLC + 57);
    end
    stuck <= 0;
    wfall();
    if (ov) begin
      cyc(4 * RWC);
      ovh <= 0;
      wfall();
    end
    chk(nhr - n0 > 0, stk || ov);
    att <= 0;
    first_msg_sent <= 0;
    contract_final <= 0;
    cz <= 0;
    cyc(RWC + 10);
  endtask
  initial begin
    logic [31:0] q;
    int n0;
    void'($urandom(32'h8536caa6));
    hp = $urandom_range(0, 1);
    high_power_select = hp;
    cyc(6);
    rstn <= 1;
    cyc(3);
    high_power_select <= !hp;
    rchk(REG_CTRL, 32'h2);
    rchk(4'h1, 32'h0);
    rchk(REG_FAULT, 32'h0);
    for (int k = 0; k < 4; k++) begin
      bus(1, REG_CTRL, {30'h0, 1'b1, k[1]}, q);
      mid_voltage_enable_first <= k[1] ? !k[0] : k[0];
      mid_voltage_enable_second <= k[1] ? k[0] : !k[0];
      cyc(1);
      caps_send_req <= 1;
      cyc(1);
      caps_send_req <= 0;
      cyc(3);
      rchk(REG_CAPS, {29'h0, hp, k[0], 1'b1});
      chk(adv_voltages, {hp, k[0], 1'b1});
      n0 = nres;
      mid_voltage_enable_first <= !mid_voltage_enable_first;
      mid_voltage_enable_second <= !mid_voltage_enable_second;
      cyc(4);
      rchk(REG_CAPS, {29'h0, hp, k[0], 1'b1});
      chk(nres - n0, 0);
      power_halving_control <= !power_halving_control;
      cyc(4);
      chk(nres - n0, 1);
    end
    for (int i = 0; i < 13; i++) run(i, 0, 0);
    rchk(REG_FAULT, 32'h3);
    bus(1, REG_FAULT, 32'hf, q);
    rchk(REG_FAULT, 32'h0);
    run(1, 1, 0);
    rchk(REG_FAULT, 32'h5);
    bus(1, REG_FAULT, 32'hf, q);
    run(8, 0, 1);
    rchk(REG_FAULT, 32'ha);
    report_and_stop();
  end
  // More than ten times the expected length of the sequence
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
endmodule // vfds_sequencer_tb_top
